// ===== uart_rx_pkg.sv
// Constants shared by the serial receiver status block and its sample-tick generator.
// Assumes a word-addressed Avalon-MM slave; the byte address is four times the index.
package uart_rx_pkg;
  // Register word indices.
  localparam int ADDR_W = 5;
  localparam logic [4:0] IDX_CONTROL_TWO = 5'h13;
  localparam logic [4:0] IDX_CONTROL_THREE = 5'h14;
  localparam logic [4:0] IDX_DATA_BUFFER = 5'h15;
  localparam logic [4:0] IDX_STATUS_ONE = 5'h16;
  localparam logic [4:0] IDX_STATUS_TWO = 5'h17;
  localparam logic [4:0] IDX_BAUD = 5'h18;
  localparam logic [4:0] IDX_FRAME_CFG = 5'h19;
  // Field positions.
  localparam int CT2_FULL_IE = 5;
  localparam int CT2_IDLE_IE = 4;
  localparam int CT2_RX_EN = 2;
  localparam int CT3_NINTH = 7;
  localparam int CT3_OVR_IE = 3;
  localparam int CT3_NOISE_IE = 2;
  localparam int CT3_FRAME_IE = 1;
  localparam int CT3_PARITY_IE = 0;
  localparam int ST1_FULL = 5;
  localparam int ST1_IDLE = 4;
  localparam int ST1_OVR = 3;
  localparam int ST1_NOISE = 2;
  localparam int ST1_FRAME = 1;
  localparam int ST1_PARITY = 0;
  localparam int ST2_BREAK = 1;
  localparam int ST2_RPF = 0;
  localparam int BAUD_LIN = 6;
  localparam int BAUD_PRE_LSB = 4;
  localparam int CFG_NINE = 0;
  localparam int CFG_PAR_EN = 1;
  localparam int CFG_PAR_ODD = 2;
  // Reset values and writable bit masks.
  localparam logic [7:0] CT2_RESET = 8'h00;
  localparam logic [7:0] CT3_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CT2_WMASK = 8'h34;
  localparam logic [7:0] CT3_WMASK = 8'h0F;
  localparam logic [7:0] BAUD_WMASK = 8'h77;
  localparam logic [7:0] CFG_WMASK = 8'h07;
  // Baud prescaler divisors per select code.
  localparam logic [3:0] BPD_CODE0 = 4'h1;
  localparam logic [3:0] BPD_CODE1 = 4'h3;
  localparam logic [3:0] BPD_CODE2 = 4'h4;
  localparam logic [3:0] BPD_CODE3 = 4'hD;
  // Sixteen sample ticks per bit: 64 / 16 leaves a base divide of four.
  localparam int RT_BASE_DIV = 4;
  localparam logic [3:0] FIRST_SAMPLE_SLOT = 4'h0;
  localparam logic [3:0] START_S1 = 4'h2;
  localparam logic [3:0] START_S2 = 4'h4;
  localparam logic [3:0] START_S3 = 4'h6;
  localparam logic [3:0] DATA_S1 = 4'h7;
  localparam logic [3:0] DATA_S2 = 4'h8;
  localparam logic [3:0] DATA_S3 = 4'h9;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  // Character, idle and LIN break lengths in bits.
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] IDLE_BITS_8 = 4'hA;
  localparam logic [3:0] IDLE_BITS_9 = 4'hB;
  localparam logic [3:0] LIN_BRK_8 = 4'hD;
  localparam logic [3:0] LIN_BRK_9 = 4'hE;
  // Receiver sequencer states.
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BRK_EXT} rx_state_t;
endpackage

// ===== baud_rt_tick.sv
// Sample-tick generator: one pulse per receiver sample slot (16 per bit).
// Assumes the select inputs come from registers on the same clock.
`timescale 1ns/100ps
module baud_rt_tick
  import uart_rx_pkg::*;
#(
  parameter int DIV_W = 13
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Divisor selects.
  input wire logic [1:0] prescale_sel_i,
  input wire logic [2:0] divisor_sel_i,
  // Sample tick.
  output logic rt_tick_o
);
  logic [3:0] bpd;
  logic [DIV_W-1:0] period;
  logic [DIV_W-1:0] cnt_r;
  logic tick_r;

  // Prescaler divisor lookup.
  always_comb begin
    case (prescale_sel_i)
      2'h0: bpd = BPD_CODE0;
      2'h1: bpd = BPD_CODE1;
      2'h2: bpd = BPD_CODE2;
      default: bpd = BPD_CODE3;
    endcase
  end

  // Clocks per slot: base times prescaler times two to the divisor code.
  assign period = DIV_W'(RT_BASE_DIV * int'(bpd)) << divisor_sel_i;

  // Free-running slot counter; a select change applies to the slot in progress, wrapping at once if past the new end.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r >= DIV_W'(period - 1'b1)) begin
      cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign rt_tick_o = tick_r;
endmodule // baud_rt_tick

// ===== uart_rx_status_data_baud.sv
// Serial receiver with status flags, shared data buffer and baud select.
// Assumes a word-addressed Avalon-MM master on clk_sys_i and an async RxD pin.
// Operation
// - Completed character sets receive-full flag.
// - Receive-full with enable raises receiver interrupt.
// - Full clears by status-one read, data read.
// - Idle flag after 10 or 11 ones.
// - Idle with enable raises receiver interrupt.
// - Idle clears by status-one read, data read.
// - Idle re-arms only after a valid character.
// - Overrun on new character while full; discard.
// - Overrun with enable raises error interrupt.
// - Overrun clears only if seen at status read.
// - Noise flag, interrupt, read-sequence clear.
// - Zero stop bit sets framing error flag.
// - Parity mismatch sets parity error flag.
// - Break sets break, framing and full flags.
// - Break forces ninth bit zero in nine-bit.
// - Break flag never interrupts; status-two read, data read clears.
// - Break re-arms after line returns high.
// - Zero in first slot sets in-progress flag.
// - False start or idle clears in-progress flag.
// - One address: read received, write transmit data.
// - LIN select needs 13 or 14 zero bits.
// - Prescale select gives 1, 3, 4, 13.
// - Divisor select gives two to the code.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module uart_rx_status_data_baud
  import uart_rx_pkg::*;
#(
  parameter int DIV_W = 13
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Avalon-MM slave.
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial line.
  input wire logic rxd_i,
  // Transmit data to the transmitter.
  output logic [7:0] tx_data_o,
  output logic tx_load_o,
  // Interrupt requests.
  output logic rx_irq_o,
  output logic err_irq_o
);
  logic ack_r;
  logic rd_acc;
  logic wr_acc;
  logic st1_rd;
  logic st2_rd;
  logic dat_rd;
  logic [7:0] wdat;
  logic [7:0] rd_nxt;
  logic [31:0] readdata_r;
  logic [7:0] ctl2_r;
  logic [7:0] ctl3_r;
  logic [7:0] baud_reg_r;
  logic [7:0] cfg_r;
  logic [7:0] tx_data_r;
  logic tx_load_r;
  logic [7:0] rx_data_r;
  logic rx_ninth_bit_r;
  logic [5:0] st1_r;
  logic [5:0] st1_nxt;
  logic [5:0] set1;
  logic [5:0] arm1_r;
  logic break_flag_r;
  logic arm2_r;
  logic [2:0] sync_r;
  logic rx_line_r;
  logic rt_tick;
  rx_state_t state_r;
  logic [3:0] rt_cnt_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] zero_cnt_r;
  logic [1:0] smp_r;
  logic [2:0] vote;
  logic maj;
  logic unan;
  logic [8:0] data_sh_r;
  logic noise_acc_r;
  logic seen_high_r;
  logic brk_armed_r;
  logic rx_in_progress_flag_r;
  logic done_r;
  logic done_fe_r;
  logic done_brk_r;
  logic done_nf_r;
  logic [7:0] idle_cnt_r;
  logic [7:0] idle_target;
  logic idle_hit;
  logic idle_allow_r;
  logic full_busy;
  logic load;
  logic par_bad;
  logic ch_zero;
  logic rx_en;
  logic nine;
  logic lin_slave_break_sel;
  logic [3:0] nbits;
  logic [7:0] ch_data;

  assign rx_en = ctl2_r[CT2_RX_EN];
  assign nine = cfg_r[CFG_NINE];
  assign lin_slave_break_sel = baud_reg_r[BAUD_LIN];
  assign nbits = nine ? BITS_9 : BITS_8;

  // Bus handshake: one wait cycle, then the access completes.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign rd_acc = avs_read_i & ack_r;
  assign wr_acc = avs_write_i & ack_r & avs_byteenable_i[0];
  assign wdat = avs_writedata_i[7:0];
  assign st1_rd = rd_acc && (avs_address_i == IDX_STATUS_ONE);
  assign st2_rd = rd_acc && (avs_address_i == IDX_STATUS_TWO);
  assign dat_rd = rd_acc && (avs_address_i == IDX_DATA_BUFFER);
  assign avs_readdata_o = readdata_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    case (avs_address_i)
      IDX_CONTROL_TWO: rd_nxt = ctl2_r;
      IDX_CONTROL_THREE: rd_nxt = {rx_ninth_bit_r, ctl3_r[6:0]};
      IDX_DATA_BUFFER: rd_nxt = rx_data_r;
      IDX_STATUS_ONE: rd_nxt = {2'h0, st1_r};
      IDX_STATUS_TWO: rd_nxt = {6'h00, break_flag_r, rx_in_progress_flag_r};
      IDX_BAUD: rd_nxt = baud_reg_r;
      IDX_FRAME_CFG: rd_nxt = cfg_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // Read data is captured in the wait cycle and stands at the completing edge.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_r) begin
      readdata_r <= {24'h00_0000, rd_nxt};
    end
  end

  // Control, baud and frame configuration registers.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ctl2_r <= CT2_RESET;
      ctl3_r <= CT3_RESET;
      baud_reg_r <= BAUD_RESET;
      cfg_r <= CFG_RESET;
    end else if (wr_acc) begin
      case (avs_address_i)
        IDX_CONTROL_TWO: ctl2_r <= wdat & CT2_WMASK;
        IDX_CONTROL_THREE: ctl3_r <= wdat & CT3_WMASK;
        IDX_BAUD: baud_reg_r <= wdat & BAUD_WMASK;
        IDX_FRAME_CFG: cfg_r <= wdat & CFG_WMASK;
        default: ;
      endcase
    end
  end

  // Transmit side of the shared buffer; contents survive reset.
  always_ff @(posedge clk_sys_i) begin
    if (wr_acc && (avs_address_i == IDX_DATA_BUFFER)) begin
      tx_data_r <= wdat;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_load_r <= 1'b0;
    end else begin
      tx_load_r <= wr_acc && (avs_address_i == IDX_DATA_BUFFER);
    end
  end

  assign tx_data_o = tx_data_r;
  assign tx_load_o = tx_load_r;

  // Pin synchroniser: a change counts once the second and third stages agree.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sync_r <= 3'h7;
      rx_line_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], rxd_i};
      if (sync_r[1] == sync_r[2]) begin
        rx_line_r <= sync_r[2];
      end
    end
  end

  baud_rt_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .prescale_sel_i(baud_reg_r[BAUD_PRE_LSB +: 2]),
    .divisor_sel_i(baud_reg_r[2:0]),
    .rt_tick_o(rt_tick)
  );

  // Three-sample vote; disagreement among the samples marks noise.
  assign vote = {smp_r, rx_line_r};
  assign maj = (vote[0] & vote[1]) | (vote[0] & vote[2]) | (vote[1] & vote[2]);
  assign unan = (&vote) | ~(|vote);
  assign ch_data = nine ? data_sh_r[7:0] : data_sh_r[8:1];
  assign ch_zero = nine ? ~(|data_sh_r) : ~(|data_sh_r[8:1]);

  // Receive sequencer: start search, start check, data, stop, LIN break extension.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_r <= RX_IDLE;
      rt_cnt_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      zero_cnt_r <= 4'h0;
      smp_r <= 2'h3;
      data_sh_r <= 9'h000;
      noise_acc_r <= 1'b0;
      seen_high_r <= 1'b0;
      brk_armed_r <= 1'b0;
      rx_in_progress_flag_r <= 1'b0;
      done_r <= 1'b0;
      done_fe_r <= 1'b0;
      done_brk_r <= 1'b0;
      done_nf_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      done_fe_r <= 1'b0;
      done_brk_r <= 1'b0;
      done_nf_r <= 1'b0;
      if (idle_hit) begin
        rx_in_progress_flag_r <= 1'b0;
      end
      if (!rx_en) begin
        state_r <= RX_IDLE;
        seen_high_r <= 1'b0;
      end else if (rt_tick) begin
        rt_cnt_r <= rt_cnt_r + 1'b1;
        if (rx_line_r) begin
          brk_armed_r <= 1'b1;
        end
        if ((state_r == RX_START && (rt_cnt_r == START_S1 || rt_cnt_r == START_S2)) ||
            (state_r != RX_START && (rt_cnt_r == DATA_S1 || rt_cnt_r == DATA_S2))) begin
          smp_r <= {smp_r[0], rx_line_r};
        end
        case (state_r)
          RX_IDLE: begin
            rt_cnt_r <= FIRST_SAMPLE_SLOT + 1'b1;
            if (rx_line_r) begin
              seen_high_r <= 1'b1;
            end else if (seen_high_r) begin
              state_r <= RX_START;
              rx_in_progress_flag_r <= 1'b1;
            end
          end
          RX_START: begin
            if (rt_cnt_r == START_S3) begin
              noise_acc_r <= ~unan;
              if (maj) begin
                state_r <= RX_IDLE;
                seen_high_r <= 1'b1;
                rx_in_progress_flag_r <= 1'b0;
              end
            end else if (rt_cnt_r == SLOT_LAST) begin
              state_r <= RX_DATA;
              bit_cnt_r <= 4'h0;
            end
          end
          RX_DATA: begin
            if (rt_cnt_r == DATA_S3) begin
              data_sh_r <= {maj, data_sh_r[8:1]};
              noise_acc_r <= noise_acc_r | ~unan;
            end else if (rt_cnt_r == SLOT_LAST) begin
              bit_cnt_r <= bit_cnt_r + 1'b1;
              if (bit_cnt_r == nbits - 1'b1) begin
                state_r <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rt_cnt_r == DATA_S3) begin
              done_nf_r <= noise_acc_r | ~unan;
              seen_high_r <= 1'b0;
              state_r <= RX_IDLE;
              if (maj) begin
                done_r <= 1'b1;
              end else if (!ch_zero || !brk_armed_r) begin
                done_r <= 1'b1;
                done_fe_r <= 1'b1;
              end else if (lin_slave_break_sel) begin
                state_r <= RX_BRK_EXT;
                zero_cnt_r <= nbits + 4'h2;
              end else begin
                done_r <= 1'b1;
                done_brk_r <= 1'b1;
                brk_armed_r <= 1'b0;
              end
            end
          end
          RX_BRK_EXT: begin
            if (rt_cnt_r == DATA_S3) begin
              if (maj) begin
                state_r <= RX_IDLE;
                done_r <= 1'b1;
                done_fe_r <= 1'b1;
              end else if (zero_cnt_r + 1'b1 == (nine ? LIN_BRK_9 : LIN_BRK_8)) begin
                state_r <= RX_IDLE;
                done_r <= 1'b1;
                done_brk_r <= 1'b1;
                brk_armed_r <= 1'b0;
              end else begin
                zero_cnt_r <= zero_cnt_r + 1'b1;
              end
            end
          end
          default: state_r <= RX_IDLE;
        endcase
      end
    end
  end

  // Idle detector: counts sample slots of steady ones while no frame is open.
  assign idle_target = {(nine ? IDLE_BITS_9 : IDLE_BITS_8), 4'h0};
  assign idle_hit = rt_tick && rx_en && rx_line_r && (state_r == RX_IDLE) &&
                    (idle_cnt_r == idle_target - 8'h01);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      idle_cnt_r <= 8'h00;
    end else if (!rx_en || state_r != RX_IDLE || !rx_line_r) begin
      idle_cnt_r <= 8'h00;
    end else if (rt_tick && idle_cnt_r != idle_target) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  // Idle may only be flagged after a valid character since the last idle or enable.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !rx_en) begin
      idle_allow_r <= 1'b0;
    end else if (load) begin
      idle_allow_r <= 1'b1;
    end else if (idle_hit) begin
      idle_allow_r <= 1'b0;
    end
  end

  // Flag set terms; a set in the clearing cycle wins over the clear.
  assign full_busy = st1_r[ST1_FULL] & ~(dat_rd & arm1_r[ST1_FULL]);
  assign load = done_r & ~full_busy;
  assign par_bad = (nine ? ^data_sh_r : ^data_sh_r[8:1]) ^ cfg_r[CFG_PAR_ODD];

  always_comb begin
    set1 = 6'h00;
    set1[ST1_FULL] = done_r;
    set1[ST1_IDLE] = idle_hit & idle_allow_r;
    set1[ST1_OVR] = done_r & full_busy;
    set1[ST1_NOISE] = load & done_nf_r;
    set1[ST1_FRAME] = done_brk_r | (load & done_fe_r);
    set1[ST1_PARITY] = load & cfg_r[CFG_PAR_EN] & ~done_brk_r & par_bad;
    st1_nxt = set1 | (st1_r & ~(dat_rd ? arm1_r : 6'h00));
  end

  // Status-one flags and the snapshot taken by the status read.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st1_r <= 6'h00;
      arm1_r <= 6'h00;
    end else begin
      st1_r <= st1_nxt;
      if (st1_rd) begin
        arm1_r <= st1_r;
      end else if (dat_rd) begin
        arm1_r <= 6'h00;
      end
    end
  end

  // Break flag, cleared by a status-two read followed by a data read.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      break_flag_r <= 1'b0;
      arm2_r <= 1'b0;
    end else begin
      break_flag_r <= done_brk_r | (break_flag_r & ~(dat_rd & arm2_r));
      if (st2_rd) begin
        arm2_r <= break_flag_r;
      end else if (dat_rd) begin
        arm2_r <= 1'b0;
      end
    end
  end

  // Receive half of the buffer; an overrunning character is dropped, reset leaves it.
  always_ff @(posedge clk_sys_i) begin
    if (load) begin
      rx_data_r <= done_brk_r ? 8'h00 : ch_data;
      rx_ninth_bit_r <= done_brk_r ? 1'b0 : data_sh_r[8];
    end
  end

  // Interrupt requests; the break flag feeds neither.
  assign rx_irq_o = (st1_r[ST1_FULL] & ctl2_r[CT2_FULL_IE]) |
                    (st1_r[ST1_IDLE] & ctl2_r[CT2_IDLE_IE]);
  assign err_irq_o = (st1_r[ST1_OVR] & ctl3_r[CT3_OVR_IE]) |
                     (st1_r[ST1_NOISE] & ctl3_r[CT3_NOISE_IE]) |
                     (st1_r[ST1_FRAME] & ctl3_r[CT3_FRAME_IE]) |
                     (st1_r[ST1_PARITY] & ctl3_r[CT3_PARITY_IE]);
endmodule // uart_rx_status_data_baud

// ===== uart_rx_status_data_baud_properties.sv
// Checker for the receiver block: bus waits, transmit load and interrupt clearing.
// Assumes it is bound into uart_rx_status_data_baud and sees only its ports.
`timescale 1ns/100ps
module uart_rx_status_data_baud_properties
  import uart_rx_pkg::*;
#(
  parameter int DIV_W = 13
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Register bus.
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Line, transmit data and interrupts.
  input wire logic rxd_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_load_o,
  input wire logic rx_irq_o,
  input wire logic err_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Accesses that complete at this edge.
  logic rd_ok;
  logic wr_ok;
  logic buf_wr;
  assign rd_ok = avs_read_i && !avs_waitrequest_o;
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  assign buf_wr = wr_ok && avs_address_i == IDX_DATA_BUFFER && avs_byteenable_i[0];
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus wait lasted more than one cycle");
  a_first_wait: assert property ($rose(avs_read_i) || $rose(avs_write_i)
    |-> avs_waitrequest_o) else $error("new request was not held for a wait");
  a_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait asserted with no request");
  a_tx_load_cause: assert property (buf_wr |=> tx_load_o &&
    tx_data_o == $past(avs_writedata_i[7:0])) else $error("data write did not load transmit");
  a_tx_load_only: assert property (tx_load_o |-> $past(buf_wr))
    else $error("transmit load without a data write");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property (rd_ok && (avs_address_i < IDX_CONTROL_TWO ||
    avs_address_i > IDX_FRAME_CFG) |-> avs_readdata_o[7:0] == 8'h00)
    else $error("unmapped read returned data");
  a_rx_irq_clear: assert property ($fell(rx_irq_o) |-> $past(rd_ok &&
    avs_address_i == IDX_DATA_BUFFER || wr_ok && avs_address_i == IDX_CONTROL_TWO))
    else $error("receiver interrupt fell without a clearing access");
  a_err_irq_clear: assert property ($fell(err_irq_o) |-> $past(rd_ok &&
    avs_address_i == IDX_DATA_BUFFER || wr_ok && avs_address_i == IDX_CONTROL_THREE))
    else $error("error interrupt fell without a clearing access");
  a_reset_clean: assert property ($rose(rst_b_i) |-> !rx_irq_o && !err_irq_o && !tx_load_o)
    else $error("outputs active after reset");
  // Main scenarios reached.
  c_data_read: cover property (rd_ok && avs_address_i == IDX_DATA_BUFFER);
  c_rx_irq: cover property ($rose(rx_irq_o));
  c_err_irq: cover property ($rose(err_irq_o));
endmodule // uart_rx_status_data_baud_properties

bind uart_rx_status_data_baud uart_rx_status_data_baud_properties #(.DIV_W(DIV_W)) u_props (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i), .tx_data_o(tx_data_o),
  .tx_load_o(tx_load_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));

// ===== serial_node_model.sv
// Remote serial node: drives the receive line of the block.
// Assumes the caller gives bit times in clk_sys_i cycles and calls just after an edge.
`timescale 1ns/100ps
module serial_node_model (
  // Clock.
  input wire logic clk_sys_i,
  // Line towards the block.
  output logic line_o
);
  // The line idles high between frames.
  initial begin
    line_o = 1'b1;
  end
  // Sends nbits bits LSB first, each for bt cycles, then returns the line high.
  task automatic send_bits(input logic [15:0] bits, input int nbits, input int bt);
    for (int i = 0; i < nbits; i++) begin
      line_o <= bits[i];
      repeat (bt) @(posedge clk_sys_i);
    end
    line_o <= 1'b1;
  endtask
endmodule // serial_node_model

// ===== uart_rx_status_data_baud_tb_top.sv
// Self-checking bench for the receiver block with a remote serial node model.
// Assumes word-indexed bus access and 64 clocks per bit at baud code zero.
`timescale 1ns/100ps
module uart_rx_status_data_baud_tb_top import uart_rx_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, rxd_i, tx_load_o, rx_irq_o, err_irq_o;
  logic [7:0] tx_data_o;
  int errors = 0;
  int compares = 0;
  int bt = 64;
  int pd[4] = '{1, 3, 4, 13};
  // Clock of 10 ns period.
  always #5 clk_sys_i = ~clk_sys_i;
  uart_rx_status_data_baud u_uart_rx_status_data_baud (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i),
    .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
  serial_node_model u_serial_node_model (.clk_sys_i(clk_sys_i), .line_o(rxd_i));
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic check1(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // One bus access, held until the wait is sampled low.
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    n = 0;
    avs_address_i <= idx;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= {24'h000000, wd};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 100) begin
      errors++;
      $display("mismatch waitrequest expected 0 seen 1");
      tally_and_finish();
    end
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, idx, d, v);
  endtask
  task automatic rc(input string nm, input logic [4:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    check8(nm, exp, v);
  endtask
  task automatic clr();
    logic [7:0] v;
    bus(1'b0, IDX_STATUS_ONE, 8'h00, v);
    bus(1'b0, IDX_STATUS_TWO, 8'h00, v);
    bus(1'b0, IDX_DATA_BUFFER, 8'h00, v);
  endtask
  task automatic send(input logic [7:0] d, input logic stop);
    u_serial_node_model.send_bits({6'h3F, stop, d, 1'b0}, 10, bt);
  endtask
  task automatic wait_bits(input int n);
    repeat (n * bt) @(posedge clk_sys_i);
  endtask
  task automatic t_regs();
    rc("baud", IDX_BAUD, 8'h00);
    rc("control_two", IDX_CONTROL_TWO, 8'h00);
    wr(IDX_BAUD, 8'hFF);
    wr(IDX_DATA_BUFFER, 8'h5A);
    rc("baud", IDX_BAUD, 8'h77);
    check8("tx_data", 8'h5A, tx_data_o);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    check8("tx_data", 8'h5A, tx_data_o);
    wr(5'h1F, 8'hFF);
    rc("unmapped", 5'h1F, 8'h00);
    wr(IDX_BAUD, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_full_idle();
    wr(IDX_CONTROL_TWO, 8'h34);
    fork
      send(8'hA5, 1'b1);
      begin
        wait_bits(5);
        rc("status_two", IDX_STATUS_TWO, 8'h01);
      end
    join
    wait_bits(12);
    check1("rx_irq", 1'b1, rx_irq_o);
    rc("status_one", IDX_STATUS_ONE, 8'h30);
    rc("status_two", IDX_STATUS_TWO, 8'h00);
    rc("data", IDX_DATA_BUFFER, 8'hA5);
    rc("status_one", IDX_STATUS_ONE, 8'h00);
    check1("rx_irq", 1'b0, rx_irq_o);
    wait_bits(12);
    rc("status_one", IDX_STATUS_ONE, 8'h00);
    $display("test full_idle done");
  endtask
  task automatic t_overrun();
    wr(IDX_CONTROL_THREE, 8'h0F);
    send(8'h3C, 1'b1);
    wait_bits(1);
    rc("status_one", IDX_STATUS_ONE, 8'h20);
    send(8'h55, 1'b1);
    wait_bits(12);
    check1("err_irq", 1'b1, err_irq_o);
    rc("data", IDX_DATA_BUFFER, 8'h3C);
    rc("status_one", IDX_STATUS_ONE, 8'h18);
    rc("data", IDX_DATA_BUFFER, 8'h3C);
    rc("status_one", IDX_STATUS_ONE, 8'h00);
    check1("err_irq", 1'b0, err_irq_o);
    $display("test overrun done");
  endtask
  task automatic t_frame_break();
    send(8'h81, 1'b0);
    wait_bits(12);
    check1("err_irq", 1'b1, err_irq_o);
    rc("status_one", IDX_STATUS_ONE, 8'h32);
    rc("status_two", IDX_STATUS_TWO, 8'h00);
    rc("data", IDX_DATA_BUFFER, 8'h81);
    send(8'h00, 1'b0);
    wait_bits(12);
    rc("status_one", IDX_STATUS_ONE, 8'h32);
    rc("status_two", IDX_STATUS_TWO, 8'h02);
    rc("data", IDX_DATA_BUFFER, 8'h00);
    rc("status_two", IDX_STATUS_TWO, 8'h00);
    rc("status_one", IDX_STATUS_ONE, 8'h00);
    $display("test frame_break done");
  endtask
  task automatic t_lin();
    wr(IDX_BAUD, 8'h40);
    send(8'h00, 1'b0);
    wait_bits(12);
    rc("status_two", IDX_STATUS_TWO, 8'h00);
    rc("status_one", IDX_STATUS_ONE, 8'h32);
    clr();
    u_serial_node_model.send_bits(16'h0000, 13, bt);
    wait_bits(12);
    rc("status_two", IDX_STATUS_TWO, 8'h02);
    clr();
    wr(IDX_BAUD, 8'h00);
    $display("test lin done");
  endtask
  task automatic t_baud();
    wr(IDX_FRAME_CFG, 8'h02);
    for (int p = 0; p < 5; p++) begin
      wr(IDX_BAUD, (p < 4) ? {2'b00, p[1:0], 4'h0} : 8'h03);
      bt = (p < 4) ? 64 * pd[p] : 512;
      send(8'hC3 ^ p[7:0], 1'b1);
      wait_bits(12);
      rc("status_one", IDX_STATUS_ONE, {7'h18, ^(8'hC3 ^ p[7:0])});
      rc("data", IDX_DATA_BUFFER, 8'hC3 ^ p[7:0]);
    end
    bt = 64;
    wr(IDX_BAUD, 8'h00);
    $display("test baud done");
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_regs();
    t_full_idle();
    t_overrun();
    t_frame_break();
    t_lin();
    t_baud();
    tally_and_finish();
  end
endmodule // uart_rx_status_data_baud_tb_top
